// >>> hdl/qstat_pkg.sv
// Constants, field layouts and state types for the queue status tracker
package qstat_pkg;
    localparam int           AXI_ADDR_W   = 4;
    localparam int           DATA_W       = 32;
    localparam int           ENTRY_W      = 6;
    localparam int           MODE_W       = 3;
    localparam logic [3:0]   ADDR_CTRL    = 4'h0;
    localparam logic [3:0]   ADDR_STAT    = 4'h4;
    localparam logic [1:0]   RESP_OKAY    = 2'h0;
    localparam logic [1:0]   RESP_SLVERR  = 2'h2;
    // Control word fields
    localparam int           Q1_MODE_LSB  = 0;
    localparam int           Q2_MODE_LSB  = 3;
    localparam int           START_LSB    = 8;
    localparam int           STOP_BIT     = 15;
    localparam logic [15:0]  CTRL_RST     = 16'h2800;
    // Status word fields
    localparam int           OVR_BIT      = 10;
    localparam int           STATE_LSB    = 6;
    localparam int           PTR_LSB      = 0;
    // Queue operating modes
    localparam logic [2:0]   MODE_OFF     = 3'h0;
    localparam logic [2:0]   MODE_SW_ONCE = 3'h1;
    localparam logic [2:0]   MODE_SW_LOOP = 3'h2;
    localparam logic [2:0]   MODE_EXT     = 3'h3;
    localparam logic [2:0]   MODE_TIMER   = 3'h4;
    // Command table geometry
    localparam logic [5:0]   ENTRY_FIRST  = 6'h00;
    localparam logic [5:0]   LAST_ENTRY   = 6'h27;
    localparam logic [5:0]   EOQ_CODE     = 6'h3F;
    // Handoff shows trigger pending for HANDOFF_CNT + 1 cycles
    localparam logic [1:0]   HANDOFF_CNT  = 2'h2;
    // Two-bit codes per queue inside the combined state field
    localparam logic [1:0]   CODE_IDLE    = 2'h0;
    localparam logic [1:0]   CODE_PAUSE   = 2'h1;
    localparam logic [1:0]   CODE_RUN     = 2'h2;
    localparam logic [1:0]   CODE_PEND    = 2'h3;

    typedef enum logic [2:0] {
        S1_IDLE  = 3'b001,
        S1_PAUSE = 3'b010,
        S1_RUN   = 3'b100
    } first_state_e;

    typedef enum logic [5:0] {
        S2_IDLE  = 6'b000001,
        S2_PAUSE = 6'b000010,
        S2_RUN   = 6'b000100,
        S2_SUSP  = 6'b001000,
        S2_PEND  = 6'b010000,
        S2_HAND  = 6'b100000
    } second_state_e;
endpackage

// >>> hdl/sticky_flag.sv
// Sticky error flag cleared by writing zero after it was read as one
`timescale 1ns/1ps
module sticky_flag (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic rd_seen,
    input  wire logic clr_req,
    output logic      flag
);
    logic armed;
    wire  do_clr = clr_req && armed;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag  <= 1'b0;
            armed <= 1'b0;
        end else begin
            flag  <= set || (flag && !do_clr);
            armed <= (armed && !do_clr) || (rd_seen && flag);
        end
    end
endmodule

// >>> hdl/axil_slave.sv
// AXI4-Lite slave front end, one write and one read in flight
`timescale 1ns/1ps
module axil_slave (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic [qstat_pkg::AXI_ADDR_W-1:0] awaddr,
    input  wire logic                            awvalid,
    output logic                                 awready,
    input  wire logic [qstat_pkg::DATA_W-1:0]    wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output logic                                 wready,
    output logic [1:0]                           bresp,
    output logic                                 bvalid,
    input  wire logic                            bready,
    input  wire logic [qstat_pkg::AXI_ADDR_W-1:0] araddr,
    input  wire logic                            arvalid,
    output logic                                 arready,
    output logic [qstat_pkg::DATA_W-1:0]         rdata,
    output logic [1:0]                           rresp,
    output logic                                 rvalid,
    input  wire logic                            rready,
    output logic                                 wr_go,
    output logic [qstat_pkg::AXI_ADDR_W-1:0]     wr_addr,
    output logic [qstat_pkg::DATA_W-1:0]         wr_data,
    output logic [3:0]                           wr_strb,
    input  wire logic                            wr_hit,
    output logic                                 rd_go,
    output logic [qstat_pkg::AXI_ADDR_W-1:0]     rd_addr,
    input  wire logic [qstat_pkg::DATA_W-1:0]    rd_data,
    input  wire logic                            rd_hit
);
    import qstat_pkg::*;

    // Address and data each parked until both arrived
    assign wr_go = !awready && !wready && !bvalid;
    assign rd_go = !arready && !rvalid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready  <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
            rd_addr <= '0;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rd_addr <= araddr;
            end
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

// >>> hdl/dual_queue_status_tracker.sv
// Two-queue sequencer status: overrun flag, combined state, entry pointer
`timescale 1ns/1ps
// How it works
// [RULE_01] Overrun only while second queue busy
// [RULE_02] Overrun only in external or timer modes
// [RULE_03] Extra trigger during scan flags overrun, discarded
// [RULE_04] Extra trigger while pending flags overrun
// [RULE_05] Flag cleared by zero write after read
// [RULE_06] Four-bit state field at bits 9..6
// [RULE_07] First idle codes 0000 to 0011
// [RULE_08] First paused codes 0100 to 0111
// [RULE_09] First active codes 1000 to 1011
// [RULE_10] Upper state bits never both one
// [RULE_11] Disabled or waiting queue reads idle
// [RULE_12] One queue active, paused waits for trigger
// [RULE_13] First trigger aborts and suspends second
// [RULE_14] Second trigger behind active first pends
// [RULE_15] Pending shown few cycles after first leaves
// [RULE_16] Stop clears state and pointer
// [RULE_17] Freeze holds state and pointer
// [RULE_18] Six-bit pointer is read only
// [RULE_19] Pointer holds on pause, moves before active
// [RULE_20] End code leaves pointer on that entry
// [RULE_21] Table end leaves pointer at forty
// [RULE_22] First queue end leaves pointer at start
module dual_queue_status_tracker (
    input  wire logic                             CORE_CLK,
    input  wire logic                             NRST,
    input  wire logic [qstat_pkg::AXI_ADDR_W-1:0] AWADDR,
    input  wire logic                             AWVALID,
    output logic                                  AWREADY,
    input  wire logic [qstat_pkg::DATA_W-1:0]     WDATA,
    input  wire logic [3:0]                       WSTRB,
    input  wire logic                             WVALID,
    output logic                                  WREADY,
    output logic [1:0]                            BRESP,
    output logic                                  BVALID,
    input  wire logic                             BREADY,
    input  wire logic [qstat_pkg::AXI_ADDR_W-1:0] ARADDR,
    input  wire logic                             ARVALID,
    output logic                                  ARREADY,
    output logic [qstat_pkg::DATA_W-1:0]          RDATA,
    output logic [1:0]                            RRESP,
    output logic                                  RVALID,
    input  wire logic                             RREADY,
    input  wire logic                             FIRST_TRIG,
    input  wire logic                             SECOND_TRIG,
    input  wire logic                             ENTRY_DONE,
    input  wire logic [qstat_pkg::ENTRY_W-1:0]    ENTRY_CHAN,
    input  wire logic                             ENTRY_PAUSE,
    input  wire logic                             FREEZE,
    output logic [qstat_pkg::ENTRY_W-1:0]         ENTRY_INDEX,
    output logic                                  FIRST_RUN,
    output logic                                  SECOND_RUN,
    output logic                                  CONV_ABORT
);
    import qstat_pkg::*;

    logic                   wr_go;
    logic [AXI_ADDR_W-1:0]  wr_addr;
    logic [DATA_W-1:0]      wr_data;
    logic [3:0]             wr_strb;
    logic                   rd_go;
    logic [AXI_ADDR_W-1:0]  rd_addr;
    logic [DATA_W-1:0]      rd_data;
    logic [7:0]             ctrl_b [2];
    logic [15:0]            ctrl;
    logic                   freeze_m;
    logic                   freeze_s;
    first_state_e           q1;
    first_state_e           next_q1;
    second_state_e          q2;
    second_state_e          next_q2;
    logic [ENTRY_W-1:0]     ptr;
    logic [ENTRY_W-1:0]     next_ptr;
    logic [ENTRY_W-1:0]     res1;
    logic [ENTRY_W-1:0]     next_res1;
    logic [ENTRY_W-1:0]     res2;
    logic [ENTRY_W-1:0]     next_res2;
    logic [1:0]             cnt;
    logic [1:0]             next_cnt;
    logic                   next_abort;
    logic                   second_queue_overrun_flag;
    logic [DATA_W-1:0]      status_word;

    // Register decode
    wire ctrl_sel = wr_addr == ADDR_CTRL;
    wire stat_sel = wr_addr == ADDR_STAT;
    wire wr_hit   = ctrl_sel || stat_sel;
    wire ctrl_wr  = wr_go && ctrl_sel;
    wire stat_wr  = wr_go && stat_sel;
    wire rd_ctrl  = rd_addr == ADDR_CTRL;
    wire rd_stat  = rd_addr == ADDR_STAT;
    wire rd_hit   = rd_ctrl || rd_stat;
    wire stat_rd  = rd_go && rd_stat;
    // Only the flag lane matters; pointer and state writes are dropped
    wire ovr_clr  = stat_wr && wr_strb[OVR_BIT/8] && !wr_data[OVR_BIT]; // RULE_05 RULE_18

    assign rd_data = rd_ctrl ? {16'h0000, ctrl} : rd_stat ? status_word : 32'h0000_0000;

    axil_slave u_bus (
        .clk     (CORE_CLK),
        .rst_n   (NRST),
        .awaddr  (AWADDR),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .bresp   (BRESP),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .araddr  (ARADDR),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .rvalid  (RVALID),
        .rready  (RREADY),
        .wr_go   (wr_go),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_hit  (wr_hit),
        .rd_go   (rd_go),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    for (genvar b = 0; b < 2; b++) begin : g_ctrl
        always_ff @(posedge CORE_CLK) begin
            if (!NRST) begin
                ctrl_b[b] <= CTRL_RST[8*b +: 8];
            end else if (ctrl_wr && wr_strb[b]) begin
                ctrl_b[b] <= wr_data[8*b +: 8];
            end
        end
    end
    assign ctrl = {ctrl_b[1], ctrl_b[0]};

    // Freeze arrives from the system, so it is synchronised
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            freeze_m <= 1'b0;
            freeze_s <= 1'b0;
        end else begin
            freeze_m <= FREEZE;
            freeze_s <= freeze_m;
        end
    end

    wire [MODE_W-1:0]  q1_mode   = ctrl[Q1_MODE_LSB +: MODE_W];
    wire [MODE_W-1:0]  q2_mode   = ctrl[Q2_MODE_LSB +: MODE_W];
    wire [ENTRY_W-1:0] start_ptr = ctrl[START_LSB +: ENTRY_W];
    wire               stop      = ctrl[STOP_BIT];
    wire               frozen    = freeze_s;
    wire               step      = !stop && !frozen;

    // Reserved and disabled modes both leave a queue idle
    wire q1_ok    = q1_mode >= MODE_SW_ONCE && q1_mode <= MODE_TIMER; // RULE_11
    wire q2_ok    = q2_mode >= MODE_SW_ONCE && q2_mode <= MODE_TIMER; // RULE_11
    wire ovr_mode = q2_mode == MODE_EXT || q2_mode == MODE_TIMER; // RULE_02

    wire [ENTRY_W-1:0] ptr_inc = ptr + 6'h01;
    wire eoq_hit   = ENTRY_CHAN == EOQ_CODE;
    wire table_end = ptr >= LAST_ENTRY;
    wire done1     = ENTRY_DONE && q1 == S1_RUN;
    wire done2     = ENTRY_DONE && q2 == S2_RUN;
    wire end1      = eoq_hit || table_end || ptr_inc == start_ptr;
    wire end2      = eoq_hit || table_end;
    wire q1_start  = q1_ok && FIRST_TRIG && q1 != S1_RUN;
    wire q1_leave  = q1 == S1_RUN && (!q1_ok || (done1 && (end1 || ENTRY_PAUSE)));
    wire q1_holds  = q1_start || (q1 == S1_RUN && !q1_leave);
    wire q2_busy   = q2 inside {S2_RUN, S2_SUSP, S2_PEND, S2_HAND};
    wire ovr_set   = step && q2_ok && ovr_mode && SECOND_TRIG && q2_busy; // RULE_01 RULE_03 RULE_04

    // Pause and end-code entries keep the pointer, others step past
    wire [ENTRY_W-1:0] end_ptr = (eoq_hit || ENTRY_PAUSE) ? ptr : ptr_inc; // RULE_20 RULE_21 RULE_22
    wire [ENTRY_W-1:0] start2  = (q2 == S2_PAUSE) ? res2 : start_ptr; // RULE_22

    always_comb begin
        next_q1    = q1;
        next_q2    = q2;
        next_ptr   = ptr;
        next_res1  = res1;
        next_res2  = res2;
        next_cnt   = cnt;
        next_abort = 1'b0;
        if (!q1_ok) begin
            next_q1    = S1_IDLE;
            next_abort = q1 == S1_RUN;
        end else if (q1_start) begin
            next_q1  = S1_RUN;
            next_ptr = (q1 == S1_PAUSE) ? res1 : ENTRY_FIRST; // RULE_19
        end else if (done1) begin
            next_ptr = end_ptr; // RULE_20 RULE_21 RULE_22
            if (end1) begin
                next_q1 = S1_IDLE;
            end else if (ENTRY_PAUSE) begin
                next_q1   = S1_PAUSE; // RULE_12
                next_res1 = ptr_inc;
            end
        end
        if (!q2_ok) begin
            next_q2 = S2_IDLE;
            if (q2 == S2_RUN) begin
                next_abort = 1'b1;
            end
        end else begin
            unique case (q2)
                S2_IDLE, S2_PAUSE: begin
                    if (SECOND_TRIG) begin
                        next_res2 = start2;
                        if (q1_holds) begin
                            next_q2 = S2_PEND; // RULE_14
                        end else begin
                            next_q2  = S2_RUN; // RULE_12
                            next_ptr = start2;
                        end
                    end
                end
                S2_RUN: begin
                    if (q1_start) begin
                        next_q2    = S2_SUSP; // RULE_13
                        next_res2  = ptr;
                        next_abort = 1'b1;
                    end else if (done2) begin
                        next_ptr = end_ptr; // RULE_20 RULE_21
                        if (end2) begin
                            next_q2 = S2_IDLE;
                        end else if (ENTRY_PAUSE) begin
                            next_q2   = S2_PAUSE;
                            next_res2 = ptr_inc;
                        end
                    end
                end
                S2_SUSP: begin
                    if (!q1_holds) begin
                        next_q2  = S2_RUN; // RULE_13
                        next_ptr = res2;
                    end
                end
                S2_PEND: begin
                    if (!q1_holds) begin
                        next_q2  = S2_HAND; // RULE_15
                        next_cnt = HANDOFF_CNT;
                        next_ptr = res2; // RULE_19
                    end
                end
                S2_HAND: begin
                    if (q1_start) begin
                        next_q2 = S2_PEND;
                    end else if (cnt == 2'h0) begin
                        next_q2 = S2_RUN; // RULE_15
                    end else begin
                        next_cnt = cnt - 2'h1;
                    end
                end
                default: next_q2 = S2_IDLE;
            endcase
        end
    end

    // Stop behaves as a reset of the tracking state
    always_ff @(posedge CORE_CLK) begin
        if (!NRST || stop) begin
            q1          <= S1_IDLE; // RULE_16
            q2          <= S2_IDLE;
            ptr         <= ENTRY_FIRST; // RULE_16
            res1        <= ENTRY_FIRST;
            res2        <= ENTRY_FIRST;
            cnt         <= 2'h0;
            FIRST_RUN   <= 1'b0;
            SECOND_RUN  <= 1'b0;
            ENTRY_INDEX <= ENTRY_FIRST;
        end else if (!frozen) begin
            q1          <= next_q1; // RULE_17
            q2          <= next_q2;
            ptr         <= next_ptr; // RULE_17
            res1        <= next_res1;
            res2        <= next_res2;
            cnt         <= next_cnt;
            FIRST_RUN   <= next_q1 == S1_RUN;
            SECOND_RUN  <= next_q2 == S2_RUN;
            ENTRY_INDEX <= next_ptr;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            CONV_ABORT <= 1'b0;
        end else begin
            CONV_ABORT <= step && next_abort; // RULE_13
        end
    end

    sticky_flag u_ovr (
        .clk     (CORE_CLK),
        .rst_n   (NRST),
        .set     (ovr_set),
        .rd_seen (stat_rd),
        .clr_req (ovr_clr),
        .flag    (second_queue_overrun_flag)
    );

    // Combined state: first queue high pair, second queue low pair
    wire [1:0] code1 = (q1 == S1_RUN) ? CODE_RUN : (q1 == S1_PAUSE) ? CODE_PAUSE : CODE_IDLE;
    wire [1:0] code2 = (q2 inside {S2_RUN, S2_SUSP}) ? CODE_RUN :
                       (q2 inside {S2_PEND, S2_HAND}) ? CODE_PEND :
                       (q2 == S2_PAUSE) ? CODE_PAUSE : CODE_IDLE; // RULE_07 RULE_08 RULE_09
    wire [3:0] combined_queue_state = {code1, code2}; // RULE_06 RULE_10

    always_comb begin
        status_word                       = '0;
        status_word[OVR_BIT]              = second_queue_overrun_flag;
        status_word[STATE_LSB +: 4]       = combined_queue_state; // RULE_06
        status_word[PTR_LSB +: ENTRY_W]   = ptr; // RULE_18
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    ovr_state_a: assert property ($rose(second_queue_overrun_flag) |-> $past(q2_busy)) // RULE_01
        else $error("overrun set while second queue not busy");
    ovr_mode_a: assert property ($rose(second_queue_overrun_flag) |-> $past(ovr_mode)) // RULE_02
        else $error("overrun set in software mode");
    ovr_keep_a: assert property (ovr_set && q2 == S2_SUSP && q1 == S1_RUN && !q1_leave // RULE_03
        |=> q2 == S2_SUSP && second_queue_overrun_flag)
        else $error("overrun trigger changed queue state");
    ovr_pend_a: assert property (ovr_set && q2 == S2_PEND |=> second_queue_overrun_flag) // RULE_04
        else $error("pending overrun not flagged");
    ovr_clear_a: assert property ($fell(second_queue_overrun_flag) |-> $past(ovr_clr)) // RULE_05
        else $error("overrun flag cleared without write");
    no_reserved_a: assert property (combined_queue_state[3:2] != 2'b11) // RULE_10
        else $error("reserved state code shown");
    susp_code_a: assert property (q1 == S1_RUN && q2 == S2_SUSP |-> combined_queue_state == 4'hA) // RULE_09
        else $error("suspended code wrong");
    idle_mode_a: assert property (!q1_ok && step |=> code1 == CODE_IDLE) // RULE_11
        else $error("disabled first queue not idle");
    one_active_a: assert property (!(FIRST_RUN && SECOND_RUN)) // RULE_12
        else $error("both queues active");
    suspend_a: assert property (step && q1_start && q2 == S2_RUN && q2_ok // RULE_13
        |=> q2 == S2_SUSP && CONV_ABORT)
        else $error("second queue not suspended");
    pend_start_a: assert property (step && q2_ok && SECOND_TRIG && q2 == S2_IDLE // RULE_14
        && q1 == S1_RUN && !q1_leave |=> code2 == CODE_PEND)
        else $error("second trigger not pending");
    handoff_a: assert property (disable iff (!NRST || stop || frozen || !q2_ok) // RULE_15
        q2 == S2_PEND && !q1_holds |=> (code2 == CODE_PEND) [*3])
        else $error("handoff pending too short");
    stop_a: assert property (stop |=> combined_queue_state == 4'h0 && ptr == ENTRY_FIRST) // RULE_16
        else $error("stop did not clear status");
    freeze_a: assert property (frozen && !stop |=> $stable(combined_queue_state) && $stable(ptr)) // RULE_17
        else $error("status moved during freeze");
    eoq_ptr_a: assert property (step && done1 && eoq_hit && q2 == S2_IDLE && q2_ok // RULE_20
        && !SECOND_TRIG |=> ptr == $past(ptr))
        else $error("pointer left end-code entry");

    susp_c: cover property (q1 == S1_RUN && q2 == S2_SUSP ##[1:50] q2 == S2_RUN);
    hand_c: cover property (q2 == S2_PEND ##1 q2 == S2_HAND ##3 q2 == S2_RUN);
    ovr_c: cover property ($rose(second_queue_overrun_flag) ##[1:50] ovr_clr);
endmodule

// >>> bench/dual_queue_status_tracker_tb.sv
// Bench for the queue status tracker: bus tasks and queue event sequences
`timescale 1ns/1ps
module dual_queue_status_tracker_tb;
    logic        core_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, ftrig = 0, strig = 0, edone = 0;
    logic        epause = 0, frz = 0;
    logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hF;
    logic [31:0] wdata = 0, rdata;
    logic [5:0]  echan = 0, eidx;
    logic [1:0]  bresp, rresp, b_seen;
    logic        awready, wready, bvalid, arready, rvalid, frun, srun, abort;
    int          mismatches = 0, n_compared = 0, n_abort = 0, t_run = 0;
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (abort === 1'b1) n_abort++;
    dual_queue_status_tracker i_dut (.CORE_CLK(core_clk), .NRST(nrst),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .FIRST_TRIG(ftrig), .SECOND_TRIG(strig),
        .ENTRY_DONE(edone), .ENTRY_CHAN(echan), .ENTRY_PAUSE(epause),
        .FREEZE(frz), .ENTRY_INDEX(eidx), .FIRST_RUN(frun),
        .SECOND_RUN(srun), .CONV_ABORT(abort));
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        logic ok;
        @(posedge core_clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1; ok = 0;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge core_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                ok = 1; bready <= 0; b_seen = bresp;
            end
        end
        if (!ok) begin
            mismatches++; conclude;
        end
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ok;
        @(posedge core_clk);
        araddr <= a; arvalid <= 1; rready <= 1; ok = 0;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge core_clk);
            if (arready) arvalid <= 0;
            if (rvalid) begin
                ok = 1; d = rdata; r = rresp; rready <= 0;
            end
        end
        if (!ok) begin
            mismatches++; conclude;
        end
    endtask
    // One-cycle event pulse; t_run counts edges until SECOND_RUN is seen
    task automatic ev(input int k, input logic [5:0] ch, input logic p = 0);
        @(posedge core_clk);
        ftrig <= (k == 1); strig <= (k == 2); edone <= (k == 3); echan <= ch; epause <= p;
        t_run = 0;
        for (int i = 1; i < 8; i++) begin
            @(posedge core_clk);
            ftrig <= 0; strig <= 0; edone <= 0; epause <= 0;
            if (t_run == 0 && srun === 1'b1) t_run = i;
        end
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (8) @(posedge core_clk);
        nrst <= 1;
        rd(4'h0, d, r); chk("ctrl", 32'h2800, d);
        rd(4'h4, d, r); chk("status", 32'h0, d);
        rd(4'hC, d, r); chk("rresp", 32'h2, 32'(r));
        wr(4'h0, 32'h101B);
        ev(2, 0); rd(4'h4, d, r); chk("state", 32'h80, d & 32'h7C0);
        ev(2, 0); rd(4'h4, d, r); chk("ovr", 32'h480, d & 32'h7C0);
        wr(4'h4, 32'h0); rd(4'h4, d, r); chk("clr", 32'h80, d & 32'h7C0);
        ev(1, 0); rd(4'h4, d, r); chk("susp", 32'h280, d & 32'h7C0);
        chk("abort", 32'h1, 32'(n_abort));
        ev(2, 0); rd(4'h4, d, r); chk("ovr_s", 32'h680, d & 32'h7C0);
        ev(3, 6'h3F); rd(4'h4, d, r); chk("resume", 32'h480, d & 32'h7C0);
        wr(4'h0, 32'h901B); rd(4'h4, d, r); chk("stop", 32'h400, d);
        wr(4'h4, 32'h0); wr(4'h0, 32'h0009);
        ev(2, 0); ev(2, 0); rd(4'h4, d, r); chk("sw", 32'h80, d & 32'h7C0);
        wr(4'h0, 32'h901B); wr(4'h0, 32'h101B); chk("bresp_ok", 32'h0, 32'(b_seen));
        ev(1, 0); ev(3, 5, 1); rd(4'h4, d, r); chk("pause", 32'h100, d);
        ev(2, 0); rd(4'h4, d, r); chk("q2_in_pause", 32'h190, d);
        chk("run_q2", 32'h1, 32'({frun, srun}));
        ev(1, 0); rd(4'h4, d, r); chk("resume1", 32'h281, d);
        chk("run_q1", 32'h2, 32'({frun, srun}));
        ev(3, 6'h3F); ev(3, 6'h3F); rd(4'h4, d, r); chk("eoq", 32'h010, d);
        ev(1, 0); ev(2, 0); rd(4'h4, d, r); chk("pend", 32'h2C0, d);
        ev(2, 0); rd(4'h4, d, r); chk("ovr_p", 32'h6C0, d);
        ev(3, 6'h3F); chk("handoff", 32'(qstat_pkg::HANDOFF_CNT + 3), 32'(t_run));
        wr(4'h4, 32'h7FF); rd(4'h4, d, r); chk("ro", 32'h490, d);
        frz <= 1; repeat (3) @(posedge core_clk);
        ev(3, 6'h3F); rd(4'h4, d, r); chk("frz", 32'h490, d);
        frz <= 0; repeat (2) @(posedge core_clk);
        ev(3, 6'h3F); wr(4'h0, 32'h301B); ev(1, 0); repeat (40) ev(3, 5);
        chk("tab_end", 32'h28, 32'(eidx));
        ev(2, 0); chk("q2_high", 32'h30, 32'(eidx));
        ev(3, 6'h3F); ev(1, 0); ev(3, 5); ev(3, 6'h3F);
        chk("eoq1", 32'h1, 32'(eidx));
        wr(4'h0, 32'h011B); ev(1, 0); ev(3, 5);
        chk("q1_end", 32'h1, 32'(eidx));
        wr(4'h8, 32'h0); chk("bresp_err", 32'h2, 32'(b_seen));
        conclude;
    end
endmodule
